// ==== design/elra_regs.svh ====
// Offsets, field positions and widths of the result and threshold registers
`ifndef ELRA_REGS_SVH
`define ELRA_REGS_SVH
`define ELRA_ADDR_W 10
`define ELRA_OFF_RATE_LO 10'h206
`define ELRA_OFF_RATE_HI 10'h207
`define ELRA_OFF_TEMP_THRESHOLD_CODE_LO 10'h208
`define ELRA_OFF_TEMP_THRESHOLD_CODE_HI 10'h209
`define ELRA_OFF_HUMIDITY_THRESHOLD_CODE_LO 10'h20A
`define ELRA_OFF_HUMIDITY_THRESHOLD_CODE_HI 10'h20B
`define ELRA_OFF_TRES_LO 10'h20C
`define ELRA_OFF_TRES_HI 10'h20D
`define ELRA_OFF_HRES_LO 10'h20E
`define ELRA_OFF_HRES_HI 10'h20F
`define ELRA_RATE_W 14
`define ELRA_RATE_HI_MASK 8'h3F
`define ELRA_RATE_ONE 14'h0001
`define ELRA_TEMP_W 11
`define ELRA_TEMP_HOT16 16'hFFE0
`define ELRA_TEMP_HOT8 8'hFF
`define ELRA_HUM_W 12
`define ELRA_TEMP_FMT_BIT 2
`define ELRA_HUM_FMT_BIT 3
`endif

// ==== design/elra_pkg.sv ====
// Types of the result and threshold register block
package elra_pkg;
  typedef enum logic [1:0] {
    ELRA_LOG_IDLE = 2'b00,
    ELRA_LOG_FIRST = 2'b01,
    ELRA_LOG_SECOND = 2'b10
  } elra_log_e;
endpackage

// ==== design/elra_result_alarm.sv ====
// Result, threshold and sample interval registers with alarm compare
//
// Summary of operation
// - Sample interval bytes ignore host writes while a mission runs.
// - Top two bits of upper interval byte always read zero.
// - Temperature is unsigned, 0.5 C per 8-bit step, 1/16 C in 16-bit.
// - Upper temp byte holds bits 10..3; lower byte bits 2..0 then zeros.
// - Lower temp byte reads 00h in 8-bit mode; upper byte always valid.
// - Too cold reads all zeros; too hot reads FFh or FFE0h.
// - Logged temperature uses the same encoding as the result register.
// - Temperature alarms compare only the upper result byte.
// - Humidity sampled on forced conversion, or in mission if enabled.
// - Every humidity acquisition takes a full 16-bit word.
// - Humidity word kept: low byte at 20Eh, high byte at 20Fh.
// - Sensor top bit lands in bit 7 of upper humidity byte.
// - Lowest four bits of the humidity word read as zeros.
// - In humidity missions the upper humidity byte is logged when the log is idle and no temp result arrives in the same cycle.
// - Lower humidity byte logged only in 16-bit humidity format.
// - Humidity format bit in mission control selects logging width.
// - Humidity is unsigned, 0.64 %RH 8-bit, 0.04 %RH 16-bit.
// - Humidity alarms compare only the upper humidity byte.
// - Humidity thresholds compare against raw sensor bytes.
// - Interval is 14-bit seconds or minutes; zero acts as one.
// - Mission temp alarms: high at or above, low at or below.
// - Mission humidity alarms: high at or above, low at or below.
// - Temp format bit selects 8 or 16-bit logging, upper byte first.
`include "elra_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module elra_result_alarm
  import elra_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_reg_wr,
  input wire logic [`ELRA_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_mission_active,
  input wire logic [7:0] i_mission_control,
  input wire logic i_humidity_log_enable,
  input wire logic i_seconds_unit_select,
  input wire logic i_temp_high_alarm_enable,
  input wire logic i_temp_low_alarm_enable,
  input wire logic i_humidity_high_alarm_enable,
  input wire logic i_humidity_low_alarm_enable,
  input wire logic i_forced_conversion,
  input wire logic i_temp_done,
  input wire logic [`ELRA_TEMP_W-1:0] i_temp_code,
  input wire logic i_temp_under,
  input wire logic i_temp_over,
  input wire logic i_humidity_done,
  input wire logic [15:0] i_humidity_word,
  output logic o_humidity_sample_req,
  output logic [`ELRA_RATE_W-1:0] o_sample_interval,
  output logic o_interval_in_seconds,
  output logic o_temp_high_flag,
  output logic o_temp_low_flag,
  output logic o_humidity_high_flag,
  output logic o_humidity_low_flag,
  output logic o_log_valid,
  output logic [7:0] o_log_byte,
  output logic o_log_is_humidity
);

  typedef struct packed {
    logic [7:0] rate_lo;
    logic [7:0] rate_hi;
    logic [7:0] temp_threshold_code_lo;
    logic [7:0] temp_threshold_code_hi;
    logic [7:0] humidity_threshold_code_lo;
    logic [7:0] humidity_threshold_code_hi;
    logic [7:0] tres_lo;
    logic [7:0] tres_hi;
    logic [7:0] hres_lo;
    logic [7:0] hres_hi;
    logic temp_high_flag;
    logic temp_low_flag;
    logic hum_high_flag;
    logic hum_low_flag;
    logic hum_req;
    elra_log_e log_state;
    logic log_hum;
    logic log_valid;
    logic [7:0] log_byte;
  } elra_state_s;

  elra_state_s state_reg;
  elra_state_s state_next;
  logic temp_fmt16;
  logic hum_fmt16;
  logic [15:0] temp_word;
  logic hum_take;

  assign temp_fmt16 = i_mission_control[`ELRA_TEMP_FMT_BIT];
  assign hum_fmt16 = i_mission_control[`ELRA_HUM_FMT_BIT];
  assign hum_take = i_humidity_done && state_reg.hum_req;

  // Saturated temperature word, same encoding for register and log
  always_comb
  begin
    if (i_temp_under)
    begin
      temp_word = 16'h0000;
    end
    else if (i_temp_over)
    begin
      temp_word = temp_fmt16 ? `ELRA_TEMP_HOT16 : {`ELRA_TEMP_HOT8, 8'h00};
    end
    else
    begin
      temp_word = {i_temp_code, 5'h00};
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.log_valid = 1'b0;
    // Interval bytes frozen during a mission
    if (i_reg_wr && !i_mission_active)
    begin
      if (i_reg_addr == `ELRA_OFF_RATE_LO)
      begin
        state_next.rate_lo = i_reg_wdata;
      end
      else if (i_reg_addr == `ELRA_OFF_RATE_HI)
      begin
        state_next.rate_hi = i_reg_wdata & `ELRA_RATE_HI_MASK;
      end
    end
    if (i_reg_wr)
    begin
      if (i_reg_addr == `ELRA_OFF_TEMP_THRESHOLD_CODE_LO)
      begin
        state_next.temp_threshold_code_lo = i_reg_wdata;
      end
      else if (i_reg_addr == `ELRA_OFF_TEMP_THRESHOLD_CODE_HI)
      begin
        state_next.temp_threshold_code_hi = i_reg_wdata;
      end
      else if (i_reg_addr == `ELRA_OFF_HUMIDITY_THRESHOLD_CODE_LO)
      begin
        state_next.humidity_threshold_code_lo = i_reg_wdata;
      end
      else if (i_reg_addr == `ELRA_OFF_HUMIDITY_THRESHOLD_CODE_HI)
      begin
        state_next.humidity_threshold_code_hi = i_reg_wdata;
      end
    end
    // Humidity request: forced conversion or humidity mission sample
    if (i_forced_conversion || (i_mission_active && i_humidity_log_enable && i_temp_done))
    begin
      state_next.hum_req = 1'b1;
    end
    else if (hum_take)
    begin
      state_next.hum_req = 1'b0;
    end
    if (i_temp_done)
    begin
      state_next.tres_hi = temp_word[15:8];
      state_next.tres_lo = temp_fmt16 ? temp_word[7:0] : 8'h00;
      if (i_mission_active)
      begin
        if (i_temp_high_alarm_enable && temp_word[15:8] >= state_reg.temp_threshold_code_hi)
        begin
          state_next.temp_high_flag = 1'b1;
        end
        if (i_temp_low_alarm_enable && temp_word[15:8] <= state_reg.temp_threshold_code_lo)
        begin
          state_next.temp_low_flag = 1'b1;
        end
      end
    end
    if (hum_take)
    begin
      state_next.hres_hi = i_humidity_word[15:8];
      state_next.hres_lo = {i_humidity_word[7:4], 4'h0};
      if (i_mission_active)
      begin
        if (i_humidity_high_alarm_enable && i_humidity_word[15:8] >= state_reg.humidity_threshold_code_hi)
        begin
          state_next.hum_high_flag = 1'b1;
        end
        if (i_humidity_low_alarm_enable && i_humidity_word[15:8] <= state_reg.humidity_threshold_code_lo)
        begin
          state_next.hum_low_flag = 1'b1;
        end
      end
    end
    // Log stream, upper byte first
    case (state_reg.log_state)
      ELRA_LOG_IDLE:
      begin
        if (i_mission_active && i_temp_done)
        begin
          state_next.log_valid = 1'b1;
          state_next.log_hum = 1'b0;
          state_next.log_byte = temp_word[15:8];
          state_next.log_state = temp_fmt16 ? ELRA_LOG_FIRST : ELRA_LOG_IDLE;
        end
        else if (i_mission_active && i_humidity_log_enable && hum_take)
        begin
          state_next.log_valid = 1'b1;
          state_next.log_hum = 1'b1;
          state_next.log_byte = i_humidity_word[15:8];
          state_next.log_state = hum_fmt16 ? ELRA_LOG_SECOND : ELRA_LOG_IDLE;
        end
      end
      ELRA_LOG_FIRST:
      begin
        state_next.log_valid = 1'b1;
        state_next.log_hum = 1'b0;
        state_next.log_byte = state_reg.tres_lo;
        state_next.log_state = ELRA_LOG_IDLE;
      end
      ELRA_LOG_SECOND:
      begin
        state_next.log_valid = 1'b1;
        state_next.log_hum = 1'b1;
        state_next.log_byte = state_reg.hres_lo;
        state_next.log_state = ELRA_LOG_IDLE;
      end
      default:
      begin
        state_next.log_state = ELRA_LOG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= '0;
      state_reg.log_state <= ELRA_LOG_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Register read mux
  always_comb
  begin
    if (i_reg_addr == `ELRA_OFF_RATE_LO)
    begin
      o_reg_rdata = state_reg.rate_lo;
    end
    else if (i_reg_addr == `ELRA_OFF_RATE_HI)
    begin
      o_reg_rdata = state_reg.rate_hi & `ELRA_RATE_HI_MASK;
    end
    else if (i_reg_addr == `ELRA_OFF_TEMP_THRESHOLD_CODE_LO)
    begin
      o_reg_rdata = state_reg.temp_threshold_code_lo;
    end
    else if (i_reg_addr == `ELRA_OFF_TEMP_THRESHOLD_CODE_HI)
    begin
      o_reg_rdata = state_reg.temp_threshold_code_hi;
    end
    else if (i_reg_addr == `ELRA_OFF_HUMIDITY_THRESHOLD_CODE_LO)
    begin
      o_reg_rdata = state_reg.humidity_threshold_code_lo;
    end
    else if (i_reg_addr == `ELRA_OFF_HUMIDITY_THRESHOLD_CODE_HI)
    begin
      o_reg_rdata = state_reg.humidity_threshold_code_hi;
    end
    else if (i_reg_addr == `ELRA_OFF_TRES_LO)
    begin
      o_reg_rdata = state_reg.tres_lo;
    end
    else if (i_reg_addr == `ELRA_OFF_TRES_HI)
    begin
      o_reg_rdata = state_reg.tres_hi;
    end
    else if (i_reg_addr == `ELRA_OFF_HRES_LO)
    begin
      o_reg_rdata = state_reg.hres_lo;
    end
    else if (i_reg_addr == `ELRA_OFF_HRES_HI)
    begin
      o_reg_rdata = state_reg.hres_hi;
    end
    else
    begin
      o_reg_rdata = 8'h00;
    end
  end

  // Zero interval behaves as one
  always_comb
  begin
    o_sample_interval = {state_reg.rate_hi[5:0], state_reg.rate_lo};
    if (o_sample_interval == '0)
    begin
      o_sample_interval = `ELRA_RATE_ONE;
    end
  end

  assign o_interval_in_seconds = i_seconds_unit_select;
  assign o_humidity_sample_req = state_reg.hum_req;
  assign o_temp_high_flag = state_reg.temp_high_flag;
  assign o_temp_low_flag = state_reg.temp_low_flag;
  assign o_humidity_high_flag = state_reg.hum_high_flag;
  assign o_humidity_low_flag = state_reg.hum_low_flag;
  assign o_log_valid = state_reg.log_valid;
  assign o_log_byte = state_reg.log_byte;
  assign o_log_is_humidity = state_reg.log_hum;

  a_rate_frozen: assert property (@(posedge i_clk) disable iff (i_reset)
    i_mission_active && $stable(i_mission_active) && !$past(i_reset)
      |-> $stable(state_reg.rate_lo))
    else $error("interval low changed in mission");
  a_rate_top_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    state_reg.rate_hi[7:6] == 2'b00)
    else $error("interval top bits set");
  a_rate_zero_one: assert property (@(posedge i_clk) disable iff (i_reset)
    o_sample_interval != '0)
    else $error("interval reads zero");
  a_temp_hot: assert property (@(posedge i_clk) disable iff (i_reset)
    i_temp_done && i_temp_over && !i_temp_under |=> state_reg.tres_hi == 8'hFF)
    else $error("hot not saturated");
  a_temp_cold: assert property (@(posedge i_clk) disable iff (i_reset)
    i_temp_done && i_temp_under |=> state_reg.tres_hi == 8'h00 && state_reg.tres_lo == 8'h00)
    else $error("cold not zero");
  a_temp_low_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    state_reg.tres_lo[4:0] == 5'h00)
    else $error("temp low bits set");
  a_hum_high_byte: assert property (@(posedge i_clk) disable iff (i_reset)
    hum_take |=> state_reg.hres_hi == $past(i_humidity_word[15:8]))
    else $error("humidity upper byte wrong");
  a_temp_hi_alarm: assert property (@(posedge i_clk) disable iff (i_reset)
    i_mission_active && i_temp_done && i_temp_high_alarm_enable && !i_temp_under
      && !i_temp_over && {i_temp_code, 5'h00} >= {state_reg.temp_threshold_code_hi, 8'h00}
      |=> o_temp_high_flag)
    else $error("temp high alarm missed");
  a_hum_lo_alarm: assert property (@(posedge i_clk) disable iff (i_reset)
    i_mission_active && hum_take && i_humidity_low_alarm_enable
      && i_humidity_word[15:8] <= state_reg.humidity_threshold_code_lo |=> o_humidity_low_flag)
    else $error("humidity low alarm missed");
  sequence s_hum16_log;
    o_log_valid && o_log_is_humidity && state_reg.log_state == ELRA_LOG_SECOND;
  endsequence
  a_hum_pair: assert property (@(posedge i_clk) disable iff (i_reset)
    s_hum16_log |=> o_log_valid && o_log_is_humidity)
    else $error("humidity low byte not logged");

endmodule // elra_result_alarm
`default_nettype wire

// ==== testbench/elra_sensor_model.sv ====
// Temperature converter and humidity sensor front end model
`timescale 1ns/10ps
`default_nettype none
module elra_sensor_model (
  input wire logic i_clk,
  input wire logic i_humidity_sample_req,
  input wire logic [3:0] i_delay,
  input wire logic [15:0] i_humidity_value,
  output logic o_temp_done,
  output logic [10:0] o_temp_code,
  output logic o_temp_under,
  output logic o_temp_over,
  output logic o_humidity_done,
  output logic [15:0] o_humidity_word
);
  logic [3:0] wait_cnt = 4'h0;
  initial
  begin
    o_temp_done = 1'b0;
    o_temp_code = 11'h000;
    o_temp_under = 1'b0;
    o_temp_over = 1'b0;
    o_humidity_done = 1'b0;
    o_humidity_word = 16'h0000;
  end
  // One-cycle result, then lines released to inverted values
  task automatic convert(input logic [10:0] code, input logic under, input logic over);
    @(posedge i_clk);
    o_temp_done <= 1'b1;
    o_temp_code <= code;
    o_temp_under <= under;
    o_temp_over <= over;
    @(posedge i_clk);
    o_temp_done <= 1'b0;
    o_temp_code <= ~code;
    o_temp_under <= ~under;
    o_temp_over <= ~over;
  endtask
  // Answer a request after i_delay cycles; word toggles when not valid
  always @(posedge i_clk)
  begin
    o_humidity_done <= 1'b0;
    if (i_humidity_sample_req && !o_humidity_done && wait_cnt >= i_delay)
    begin
      o_humidity_done <= 1'b1;
      o_humidity_word <= i_humidity_value;
      wait_cnt <= 4'h0;
    end
    else
    begin
      o_humidity_word <= ~o_humidity_word;
      wait_cnt <= i_humidity_sample_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // elra_sensor_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Register access, result and alarm tests of the result block
`timescale 1ns/10ps
`default_nettype none
`include "elra_regs.svh"
`define CHK(a, e) cmp(16'(a), 16'(e));
module tb_top;
  logic i_clk, i_reset, i_reg_wr, i_mission_active, i_humidity_log_enable;
  logic i_seconds_unit_select, i_temp_high_alarm_enable, i_temp_low_alarm_enable;
  logic i_humidity_high_alarm_enable, i_humidity_low_alarm_enable, i_forced_conversion;
  logic i_temp_done, i_temp_under, i_temp_over, i_humidity_done, o_humidity_sample_req;
  logic o_interval_in_seconds, o_log_valid, o_log_is_humidity, o_temp_high_flag;
  logic o_temp_low_flag, o_humidity_high_flag, o_humidity_low_flag;
  logic [`ELRA_ADDR_W-1:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, i_mission_control, o_log_byte;
  logic [`ELRA_TEMP_W-1:0] i_temp_code;
  logic [15:0] i_humidity_word, hum_value;
  logic [`ELRA_RATE_W-1:0] o_sample_interval;
  logic [3:0] delay;
  logic [8:0] logq[$];
  int err_count, cmp_count;
  elra_result_alarm dut (.i_clk, .i_reset, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_mission_active, .i_mission_control, .i_humidity_log_enable,
    .i_seconds_unit_select, .i_temp_high_alarm_enable, .i_temp_low_alarm_enable,
    .i_humidity_high_alarm_enable, .i_humidity_low_alarm_enable, .i_forced_conversion,
    .i_temp_done, .i_temp_code, .i_temp_under, .i_temp_over, .i_humidity_done,
    .i_humidity_word, .o_humidity_sample_req, .o_sample_interval, .o_interval_in_seconds,
    .o_temp_high_flag, .o_temp_low_flag, .o_humidity_high_flag, .o_humidity_low_flag,
    .o_log_valid, .o_log_byte, .o_log_is_humidity);
  elra_sensor_model fe (.i_clk, .i_humidity_sample_req(o_humidity_sample_req),
    .i_delay(delay), .i_humidity_value(hum_value), .o_temp_done(i_temp_done),
    .o_temp_code(i_temp_code), .o_temp_under(i_temp_under), .o_temp_over(i_temp_over),
    .o_humidity_done(i_humidity_done), .o_humidity_word(i_humidity_word));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    if (o_log_valid === 1'b1) logq.push_back({o_log_is_humidity, o_log_byte});
  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    cmp_count++;
    if (a !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_reg_addr <= a;
    #1;
    `CHK(o_reg_rdata, e)
  endtask
  task automatic lg(input logic [8:0] e);
    logic [8:0] v;
    v = (logq.size() != 0) ? logq.pop_front() : 9'bx;
    `CHK(v, e)
  endtask
  // Wait for the humidity answer, then for the log bytes
  task automatic settle();
    int n;
    n = 0;
    #1;
    while (o_humidity_sample_req !== 1'b0 && n < 50)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    repeat (3) @(posedge i_clk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    finish_test();
  end
  initial
  begin
    logic [7:0] thr [4] = '{8'h3E, 8'h85, 8'h58, 8'h97};
    {i_reset, i_reg_wr, i_reg_addr, i_reg_wdata, i_mission_active} = '0;
    i_reset = 1'b1;
    {i_mission_control, i_humidity_log_enable, i_seconds_unit_select} = '0;
    {i_temp_high_alarm_enable, i_temp_low_alarm_enable, i_forced_conversion} = '0;
    {i_humidity_high_alarm_enable, i_humidity_low_alarm_enable} = '0;
    {delay, hum_value} = '0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    wr(`ELRA_OFF_RATE_LO, 8'h00);
    wr(`ELRA_OFF_RATE_HI, 8'h00);
    i_seconds_unit_select <= 1'b1;
    rd(`ELRA_OFF_RATE_HI, 8'h00);
    `CHK(o_sample_interval, 14'h0001)
    `CHK(o_interval_in_seconds, 1'b1)
    wr(`ELRA_OFF_RATE_LO, 8'h34);
    wr(`ELRA_OFF_RATE_HI, 8'hFF);
    rd(`ELRA_OFF_RATE_HI, 8'h3F);
    `CHK(o_sample_interval, 14'h3F34)
    for (int i = 0; i < 4; i++) wr(`ELRA_OFF_TEMP_THRESHOLD_CODE_LO + 10'(i), thr[i]);
    for (int i = 0; i < 4; i++) rd(`ELRA_OFF_TEMP_THRESHOLD_CODE_LO + 10'(i), thr[i]);
    wr(10'h210, 8'hAA);
    rd(10'h210, 8'h00);
    i_mission_active <= 1'b1;
    wr(`ELRA_OFF_RATE_LO, 8'h55);
    wr(`ELRA_OFF_RATE_HI, 8'h12);
    rd(`ELRA_OFF_RATE_LO, 8'h34);
    rd(`ELRA_OFF_RATE_HI, 8'h3F);
    $display("test registers done");
    {i_temp_high_alarm_enable, i_temp_low_alarm_enable} <= 2'b11;
    i_mission_control <= 8'h04;
    fe.convert(11'h2A3, 1'b0, 1'b0);
    rd(`ELRA_OFF_TRES_HI, 8'h54);
    rd(`ELRA_OFF_TRES_LO, 8'h60);
    `CHK({o_temp_high_flag, o_temp_low_flag}, 2'b00)
    fe.convert(11'h42F, 1'b0, 1'b0);
    settle();
    `CHK({o_temp_high_flag, o_temp_low_flag}, 2'b10)
    i_mission_control <= 8'h00;
    fe.convert(11'h7FF, 1'b1, 1'b0);
    rd(`ELRA_OFF_TRES_HI, 8'h00);
    `CHK(o_temp_low_flag, 1'b1)
    fe.convert(11'h000, 1'b0, 1'b1);
    rd(`ELRA_OFF_TRES_HI, 8'hFF);
    i_mission_control <= 8'h04;
    fe.convert(11'h000, 1'b0, 1'b1);
    rd(`ELRA_OFF_TRES_LO, 8'hE0);
    settle();
    lg(9'h054);
    lg(9'h060);
    lg(9'h085);
    lg(9'h0E0);
    lg(9'h000);
    lg(9'h0FF);
    lg(9'h0FF);
    lg(9'h0E0);
    $display("test temperature done");
    i_mission_active <= 1'b0;
    {i_humidity_high_alarm_enable, i_humidity_low_alarm_enable} <= 2'b11;
    {delay, hum_value} <= {4'h2, 16'hB5C7};
    @(posedge i_clk);
    i_forced_conversion <= 1'b1;
    @(posedge i_clk);
    i_forced_conversion <= 1'b0;
    #1;
    `CHK(o_humidity_sample_req, 1'b1)
    settle();
    rd(`ELRA_OFF_HRES_HI, 8'hB5);
    rd(`ELRA_OFF_HRES_LO, 8'hC0);
    `CHK(o_humidity_high_flag, 1'b0)
    `CHK(logq.size(), 0)
    {i_mission_active, i_humidity_log_enable, i_mission_control} <= {2'b11, 8'h0C};
    hum_value <= 16'h9712;
    fe.convert(11'h2A3, 1'b0, 1'b0);
    settle();
    {i_mission_control, hum_value} <= {8'h04, 16'h58FF};
    fe.convert(11'h2A3, 1'b0, 1'b0);
    settle();
    `CHK({o_humidity_high_flag, o_humidity_low_flag}, 2'b11)
    lg(9'h054);
    lg(9'h060);
    lg(9'h197);
    lg(9'h110);
    lg(9'h054);
    lg(9'h060);
    lg(9'h158);
    `CHK(logq.size(), 0)
    i_humidity_log_enable <= 1'b0;
    fe.convert(11'h2A3, 1'b0, 1'b0);
    #1;
    `CHK(o_humidity_sample_req, 1'b0)
    $display("test humidity done");
    @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    `CHK({o_temp_high_flag, o_temp_low_flag, o_humidity_high_flag, o_humidity_low_flag}, 0)
    $display("test reset done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
